// [core/fmio_consts.svh]
`ifndef FMIO_CONSTS_SVH
`define FMIO_CONSTS_SVH
`define FMIO_CLK_HZ 20000000
`define FMIO_FREQ_MIN_HZ 2
`define FMIO_FREQ_MAX_HZ 10000
// nco step per Hz: 2^36 / clock rate, rounded
`define FMIO_NCO_W 36
`define FMIO_NCO_K 3436
`define FMIO_TOT_MAX_HZ 50
`define FMIO_TOT_GAP_CYC (`FMIO_CLK_HZ / (2 * `FMIO_TOT_MAX_HZ))
`define FMIO_ZERO_FAST_S 10
`define FMIO_ZERO_SLOW_S 30
`define FMIO_ZERO_FAST_CYC (`FMIO_ZERO_FAST_S * `FMIO_CLK_HZ)
`define FMIO_ZERO_SLOW_CYC (`FMIO_ZERO_SLOW_S * `FMIO_CLK_HZ)
`define FMIO_ANA_FULL 65535
`define FMIO_OWED_MAX 8'hFF
`endif

// [core/fmio_pkg.sv]
package fmio_pkg;
	typedef enum logic {PM_RATE, PM_TOTAL} fmio_pmode_e;
	typedef enum logic [2:0] {CM_OFF, CM_FAULT, CM_DIR, CM_BATCH, CM_LIMIT, CM_SIGN,
		CM_PHASE} fmio_cmode_e;
	typedef enum logic [1:0] {IM_OFF, IM_ZERO, IM_BATCH, IM_HOLD} fmio_imode_e;
	typedef enum logic [1:0] {AS_FLOW, AS_DENSITY, AS_TEMP, AS_BATCH} fmio_asrc_e;
endpackage : fmio_pkg

// [core/fmio_io_logic.sv]
`timescale 1ns/1ns
`include "fmio_consts.svh"
module fmio_io_logic #(
	parameter int unsigned ZERO_FAST_CYC = `FMIO_ZERO_FAST_CYC, // fast zero length
	parameter int unsigned ZERO_SLOW_CYC = `FMIO_ZERO_SLOW_CYC, // slow zero length
	parameter int unsigned TOT_GAP_CYC = `FMIO_TOT_GAP_CYC // min cycles between edges
) (
	input wire logic i_clk, // 20 MHz clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_cfg_we, // host config write strobe
	input wire fmio_pkg::fmio_pmode_e i_cfg_pmode, // pulse output mode
	input wire fmio_pkg::fmio_cmode_e i_cfg_cmode, // control output mode
	input wire fmio_pkg::fmio_imode_e i_cfg_imode, // control input mode
	input wire fmio_pkg::fmio_asrc_e i_cfg_asrc, // analog source
	input wire logic i_cfg_test, // io test mode
	input wire logic i_cfg_zslow, // slow zero procedure
	input wire logic signed [23:0] i_flow, // filtered flow
	input wire logic [23:0] i_cutoff, // low flow suppression level
	input wire logic [15:0] i_hz_gain, // Hz per flow unit, 8.8 fixed
	input wire logic i_tick, // totaliser sample strobe
	input wire logic signed [23:0] i_inc, // quantity for this tick
	input wire logic [23:0] i_step, // total increment step
	input wire logic i_fault, // device error present
	input wire logic [31:0] i_batch_preset, // batch preset value
	input wire logic signed [23:0] i_limit, // flow limit
	input wire logic [23:0] i_hyst, // limit hysteresis
	input wire logic signed [23:0] i_density, // density value
	input wire logic signed [23:0] i_temp, // temperature value
	input wire logic signed [31:0] i_ana_lo, // value at 4 mA
	input wire logic signed [31:0] i_ana_hi, // value at 20 mA
	input wire logic [13:0] i_test_hz, // test frequency
	input wire logic i_test_level, // test control level
	input wire logic [15:0] i_test_ana, // test analog code
	input wire logic i_ctl_in, // control input pin
	output logic o_pulse, // pulse output pin
	output logic o_ctl, // control output pin
	output logic [15:0] o_ana_code, // 4..20 mA code, 0 = 4 mA
	output logic o_ctl_in_level, // synchronised input level
	output logic o_zero_busy, // zero procedure running
	output logic o_hold, // totals held
	output logic [31:0] o_batch // batch count
);
	import fmio_pkg::*;

	fmio_pmode_e pmode_reg;
	fmio_cmode_e cmode_reg;
	fmio_imode_e imode_reg;
	fmio_asrc_e asrc_reg;
	logic test_reg, zslow_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pmode_reg <= PM_RATE;
			cmode_reg <= CM_OFF;
			imode_reg <= IM_OFF;
			asrc_reg <= AS_FLOW;
			test_reg <= 1'b0;
			zslow_reg <= 1'b0;
		end else if (i_cfg_we) begin
			pmode_reg <= i_cfg_pmode;
			cmode_reg <= i_cfg_cmode;
			imode_reg <= i_cfg_imode;
			asrc_reg <= i_cfg_asrc;
			test_reg <= i_cfg_test;
			zslow_reg <= i_cfg_zslow;
		end
	end

	// input pin synchroniser; sync2 and lvl_prev_reg are read, sync1 only feeds sync2
	logic sync1_reg, sync2_reg, lvl_prev_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			lvl_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= i_ctl_in;
			sync2_reg <= sync1_reg;
			lvl_prev_reg <= sync2_reg;
		end
	end
	wire in_zero = imode_reg == IM_ZERO && !test_reg;
	wire in_batch = imode_reg == IM_BATCH && !test_reg;
	wire in_hold = imode_reg == IM_HOLD && !test_reg;
	wire zero_start = in_zero && sync2_reg && !lvl_prev_reg;
	wire batch_clr = in_batch && !sync2_reg;
	wire hold_act = in_hold && !sync2_reg;

	// low flow suppression
	wire [23:0] abs_flow = i_flow[23] ? 24'(-i_flow) : i_flow;
	wire below_cut = abs_flow < i_cutoff;
	wire signed [23:0] flow_eff = below_cut ? 24'sh000000 : i_flow;
	wire [23:0] abs_eff = below_cut ? 24'h000000 : abs_flow;
	wire tot_acc = i_tick && !below_cut && !hold_act;

	// rate mode frequency, phase accumulator gives 50 % duty for free
	wire [39:0] hz_prod = 40'(abs_eff) * 40'(i_hz_gain);
	wire [31:0] hz_raw = hz_prod[39:8];
	wire [13:0] hz_clamp = (abs_eff == 24'h000000) ? 14'h0000 :
		(hz_raw < 32'(`FMIO_FREQ_MIN_HZ)) ? 14'(`FMIO_FREQ_MIN_HZ) :
		(hz_raw > 32'(`FMIO_FREQ_MAX_HZ)) ? 14'(`FMIO_FREQ_MAX_HZ) : hz_raw[13:0];
	wire [13:0] nco_hz = test_reg ? i_test_hz : hz_clamp;
	wire [`FMIO_NCO_W-1:0] nco_inc = `FMIO_NCO_W'(nco_hz) * `FMIO_NCO_W'(`FMIO_NCO_K);
	logic [`FMIO_NCO_W-1:0] nco_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			nco_reg <= '0;
		else if (nco_hz == 14'h0000)
			nco_reg <= '0;
		else
			nco_reg <= nco_reg + nco_inc;
	end
	wire nco_out = nco_reg[`FMIO_NCO_W-1];

	// total mode: signed balance, reverse flow must be paid back first
	wire quad = cmode_reg == CM_PHASE && !test_reg;
	wire [23:0] thr_u = quad ? (i_step >> 2) : (i_step >> 1);
	wire signed [31:0] thr = $signed({8'h00, thr_u});
	logic signed [31:0] bal_reg;
	logic [7:0] owed_reg;
	logic [31:0] gap_reg;
	logic [1:0] edge_cnt_reg;
	wire signed [31:0] bal_sum = bal_reg + 32'(i_inc);
	wire owed_full = owed_reg == `FMIO_OWED_MAX;
	wire earn = tot_acc && thr_u != 24'h000000 && bal_sum >= thr && !owed_full;
	wire emit = owed_reg != 8'h00 && gap_reg == 32'h00000000;
	wire [31:0] gap_load = quad ? 32'(TOT_GAP_CYC / 2) - 32'h1 : 32'(TOT_GAP_CYC) - 32'h1;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bal_reg <= '0;
			owed_reg <= '0;
			gap_reg <= '0;
			edge_cnt_reg <= '0;
		end else begin
			if (tot_acc)
				bal_reg <= earn ? bal_sum - thr : bal_sum;
			owed_reg <= owed_reg + 8'(earn) - 8'(emit);
			if (emit) begin
				gap_reg <= gap_load;
				edge_cnt_reg <= edge_cnt_reg + 2'h1;
			end else if (gap_reg != 32'h00000000) begin
				gap_reg <= gap_reg - 32'h1;
			end
		end
	end
	// gray sequence 00,01,11,10 puts the two outputs a quarter period apart
	wire quad_a = edge_cnt_reg[1];
	wire quad_b = edge_cnt_reg[1] ^ edge_cnt_reg[0];

	// batch counter; reverse flow counts down
	logic [31:0] batch_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			batch_reg <= '0;
		else if (batch_clr)
			batch_reg <= '0;
		else if (tot_acc)
			batch_reg <= batch_reg + 32'(i_inc);
	end
	wire batch_done = in_batch && batch_reg >= i_batch_preset;

	// limit with hysteresis
	wire signed [25:0] lim_hi = 26'(i_limit) + $signed({2'b00, i_hyst});
	wire signed [25:0] lim_lo = 26'(i_limit) - $signed({2'b00, i_hyst});
	wire signed [25:0] flow_w = 26'(flow_eff);
	logic lim_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			lim_reg <= 1'b0;
		else if (flow_w > lim_hi)
			lim_reg <= 1'b1;
		else if (flow_w < lim_lo)
			lim_reg <= 1'b0;
	end

	// zero offset procedure timer
	logic [31:0] zero_cnt_reg;
	logic zero_busy_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			zero_cnt_reg <= '0;
			zero_busy_reg <= 1'b0;
		end else if (zero_start && !zero_busy_reg) begin
			zero_cnt_reg <= zslow_reg ? ZERO_SLOW_CYC - 1 : ZERO_FAST_CYC - 1;
			zero_busy_reg <= 1'b1;
		end else if (zero_busy_reg) begin
			zero_cnt_reg <= zero_cnt_reg - 32'h1;
			zero_busy_reg <= zero_cnt_reg != 32'h00000000;
		end
	end

	// output selection
	logic ctl_sel;
	always_comb begin
		ctl_sel = 1'b0;
		unique case (cmode_reg)
			CM_OFF: ctl_sel = 1'b0;
			CM_FAULT: ctl_sel = i_fault;
			CM_DIR: ctl_sel = !flow_eff[23];
			CM_BATCH: ctl_sel = batch_done;
			CM_LIMIT: ctl_sel = lim_reg;
			CM_SIGN: ctl_sel = flow_eff[23];
			CM_PHASE: ctl_sel = quad_b;
			default: ctl_sel = 1'b0;
		endcase
	end
	wire pulse_next = test_reg ? nco_out :
		quad ? quad_a : (pmode_reg == PM_TOTAL) ? edge_cnt_reg[0] : nco_out;
	wire ctl_next = test_reg ? i_test_level : ctl_sel;

	// analog: batch source falls back to flow unless the input clears batches
	logic signed [31:0] ana_val;
	always_comb begin
		ana_val = 32'(flow_eff);
		unique case (asrc_reg)
			AS_FLOW: ana_val = 32'(flow_eff);
			AS_DENSITY: ana_val = 32'(i_density);
			AS_TEMP: ana_val = 32'(i_temp);
			AS_BATCH: ana_val = in_batch ? $signed(batch_reg) : 32'(flow_eff);
		endcase
	end
	// full-width divide is costly but the span is free, reversed spans too
	wire signed [63:0] ana_num = (64'(ana_val) - 64'(i_ana_lo)) * 64'sd`FMIO_ANA_FULL;
	wire signed [63:0] ana_den = 64'(i_ana_hi) - 64'(i_ana_lo);
	wire signed [63:0] ana_q = (ana_den == 64'sd0) ? 64'sd0 : ana_num / ana_den;
	wire [15:0] ana_clamp = (ana_q < 64'sd0) ? 16'h0000 :
		(ana_q > 64'sd`FMIO_ANA_FULL) ? 16'hFFFF : ana_q[15:0];

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pulse <= 1'b0;
			o_ctl <= 1'b0;
			o_ana_code <= '0;
		end else begin
			o_pulse <= pulse_next;
			o_ctl <= ctl_next;
			o_ana_code <= test_reg ? i_test_ana : ana_clamp;
		end
	end
	assign o_ctl_in_level = sync2_reg;
	assign o_zero_busy = zero_busy_reg;
	assign o_hold = hold_act;
	assign o_batch = batch_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	ctl_off_low_a: assert property (cmode_reg == CM_OFF && !test_reg |=> !o_ctl)
		else $error("control output not low in off mode");
	fault_high_a: assert property (cmode_reg == CM_FAULT && !test_reg && i_fault |=> o_ctl)
		else $error("fault not shown on control output");
	dir_level_a: assert property (cmode_reg == CM_DIR && !test_reg |=> o_ctl == !$past(flow_eff[23]))
		else $error("direction output wrong");
	batch_clear_a: assert property (in_batch && !sync2_reg |=> batch_reg == 32'h0)
		else $error("batch not cleared by low input");
	hold_stops_a: assert property (hold_act |=> $stable(bal_reg) && $stable(batch_reg))
		else $error("totals moved while held");
	cutoff_total_a: assert property (below_cut && !batch_clr |=> $stable(batch_reg))
		else $error("total changed below low_flow_suppression");
	freq_range_a: assert property (!test_reg && abs_eff != 24'h0 |->
		nco_hz >= 14'd2 && nco_hz <= 14'd10000)
		else $error("rate frequency out of range");
	edge_gap_a: assert property ($changed(edge_cnt_reg) |-> $past(gap_reg) == 32'h0)
		else $error("total pulse edge too early");
	quad_apart_a: assert property (quad && $changed(edge_cnt_reg) |=>
		!($changed(o_pulse) && $changed(o_ctl)))
		else $error("quadrature outputs changed together");
	zero_start_a: assert property (zero_start && !zero_busy_reg |=> zero_busy_reg [*8])
		else $error("zero procedure did not start");
	input_off_a: assert property ($rose(zero_busy_reg) |-> $past(imode_reg) == IM_ZERO)
		else $error("zeroing started from other input mode");
	test_level_a: assert property (test_reg |=> o_ctl == $past(i_test_level))
		else $error("test level not driven");
	cover_quad_c: cover property (quad && $changed(o_pulse) ##[1:1000] $changed(o_ctl));
	cover_batch_c: cover property (in_batch && $rose(batch_done));
	cover_zero_c: cover property ($fell(zero_busy_reg));
	cover_limit_c: cover property (cmode_reg == CM_LIMIT && $rose(lim_reg));
endmodule : fmio_io_logic

// [tb/fmio_pin_model.sv]
`timescale 1ns/1ns
// far-side counter: counts pulse toggles, watches their spacing and whether both pins move in one cycle
module fmio_pin_model (
	input wire logic i_clk, // bench clock
	input wire logic i_clr, // restart the counts
	input wire logic i_pulse, // pulse pin
	input wire logic i_ctl, // control pin
	output int o_edges, // pulse toggles seen
	output int o_gap, // fewest cycles between pulse toggles
	output logic o_both // both pins moved in one cycle
);
	logic p_reg;
	logic c_reg;
	int since;
	// pins are registered, so the old level is still visible at the sampling edge
	always @(posedge i_clk) begin
		p_reg <= i_pulse;
		c_reg <= i_ctl;
		since <= since + 1;
		if (i_clr) begin
			o_edges <= 0;
			o_gap <= 999999;
			o_both <= 1'b0;
		end else if (p_reg != i_pulse) begin
			o_edges <= o_edges + 1;
			since <= 1;
			if (since < o_gap && o_edges > 0)
				o_gap <= since;
			if (c_reg != i_ctl)
				o_both <= 1'b1;
		end
	end
endmodule : fmio_pin_model

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	import fmio_pkg::*;
	localparam int ZF = 50;
	localparam int ZS = 100;
	localparam int GAP = 8;
	logic clk, pulse, ctl, lvl, busy, hold, both;
	logic nrst = 1'b0, we = 1'b0, test = 1'b0, zslow = 1'b0, tick = 1'b0, clr = 1'b1;
	logic fault = 1'b1, cin = 1'b1, tlev = 1'b0;
	fmio_pmode_e pm = PM_RATE;
	fmio_cmode_e cm = CM_OFF;
	fmio_imode_e im = IM_OFF;
	fmio_asrc_e asrc = AS_FLOW;
	logic signed [23:0] flow = 0, inc = 0, lim = 1000, dens = 0, temp = 0;
	logic [23:0] cut = 16, step = 4, hyst = 100;
	logic [15:0] gain = 16'h0100, tana = 16'h0000, ana;
	logic [13:0] thz = 14'h0000;
	logic [31:0] pre = 32'h0000000A, batch;
	logic signed [31:0] lo = 0, hi = 2000;
	int edges, gap, mismatches, tests_run, seed, n;
	int lim_f[8] = '{800, 1101, 1000, 1100, 899, 1000, 900, 1101};
	logic [7:0] lim_e = 8'h8E;
	fmio_io_logic #(.ZERO_FAST_CYC(ZF), .ZERO_SLOW_CYC(ZS), .TOT_GAP_CYC(GAP)) u_dut (
		.i_clk(clk), .i_nrst(nrst), .i_cfg_we(we), .i_cfg_pmode(pm), .i_cfg_cmode(cm),
		.i_cfg_imode(im), .i_cfg_asrc(asrc), .i_cfg_test(test), .i_cfg_zslow(zslow),
		.i_flow(flow), .i_cutoff(cut), .i_hz_gain(gain), .i_tick(tick), .i_inc(inc),
		.i_step(step), .i_fault(fault), .i_batch_preset(pre), .i_limit(lim), .i_hyst(hyst),
		.i_density(dens), .i_temp(temp), .i_ana_lo(lo), .i_ana_hi(hi), .i_test_hz(thz),
		.i_test_level(tlev), .i_test_ana(tana), .i_ctl_in(cin), .o_pulse(pulse),
		.o_ctl(ctl), .o_ana_code(ana), .o_ctl_in_level(lvl), .o_zero_busy(busy),
		.o_hold(hold), .o_batch(batch));
	fmio_pin_model u_far (.i_clk(clk), .i_clr(clr), .i_pulse(pulse), .i_ctl(ctl),
		.o_edges(edges), .o_gap(gap), .o_both(both));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic rng(string nm, int a, int b, int g);
		tests_run++;
		if (g < a || g > b) begin
			mismatches++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, a, b, g);
		end
	endtask : rng
	task automatic test_done();
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// inputs always move 5 ns after the edge, well clear of sampling
	task automatic cyc(int k);
		repeat (k) @(posedge clk);
		#5;
	endtask : cyc
	task automatic clear();
		clr = 1'b1;
		cyc(2);
		clr = 1'b0;
	endtask : clear
	task automatic cfg(fmio_pmode_e p, fmio_cmode_e c, fmio_imode_e i, fmio_asrc_e a, logic t);
		pm = p;
		cm = c;
		im = i;
		asrc = a;
		test = t;
		we = 1'b1;
		cyc(1);
		we = 1'b0;
		cyc(2);
	endtask : cfg
	task automatic tk(logic signed [23:0] v, int k);
		inc = v;
		tick = 1'b1;
		cyc(1);
		tick = 1'b0;
		cyc(k);
	endtask : tk
	task automatic wait_busy(logic v);
		n = 0;
		while (busy !== v && n < 300) begin
			cyc(1);
			n++;
		end
		if (n == 300) begin
			mismatches++;
			test_done();
		end
	endtask : wait_busy
	function automatic logic [31:0] exp_ana(logic signed [31:0] v);
		longint q;
		if (hi == lo)
			return 0;
		q = (longint'(v) - lo) * 65535 / (longint'(hi) - lo);
		return (q < 0) ? 0 : (q > 65535) ? 65535 : 32'(q);
	endfunction : exp_ana
	initial begin
		seed = 32'hada5b96c;
		cyc(3);
		nrst = 1'b1;
		cyc(2);
		chk("ctl reset", 0, 32'(ctl));
		chk("pulse reset", 0, 32'(pulse));
		for (int k = 0; k < 8; k++) begin
			flow = 24'(($random(seed) & 32'h3FFFF) + 1000);
			if ($random(seed) & 1)
				flow = -flow;
			fault = 1'($random(seed));
			dens = 24'($random(seed));
			temp = 24'($random(seed));
			lo = $random(seed) % 300000;
			hi = $random(seed) % 300000;
			cfg(PM_RATE, CM_FAULT, IM_OFF, AS_FLOW, 1'b0);
			chk("fault", 32'(fault), 32'(ctl));
			chk("ana flow", exp_ana(flow), 32'(ana));
			cfg(PM_RATE, CM_DIR, IM_OFF, AS_DENSITY, 1'b0);
			chk("dir", 32'(flow > 0), 32'(ctl));
			chk("ana dens", exp_ana(dens), 32'(ana));
			cfg(PM_RATE, CM_SIGN, IM_OFF, AS_TEMP, 1'b0);
			chk("sign", 32'(flow < 0), 32'(ctl));
			chk("ana temp", exp_ana(temp), 32'(ana));
		end
		cfg(PM_RATE, CM_LIMIT, IM_OFF, AS_FLOW, 1'b0);
		for (int k = 0; k < 8; k++) begin
			flow = 24'(lim_f[k]);
			cyc(3);
			chk("limit", 32'(lim_e[k]), 32'(ctl));
		end
		lo = 0;
		hi = 2000;
		cfg(PM_RATE, CM_BATCH, IM_BATCH, AS_BATCH, 1'b0);
		cin = 1'b0;
		cyc(5);
		chk("batch clr", 0, batch);
		cin = 1'b1;
		cyc(4);
		for (int k = 0; k < 4; k++) begin
			chk("batch out", 0, 32'(ctl));
			tk(24'sd3, 4);
		end
		chk("batch cnt", 12, batch);
		chk("batch out", 1, 32'(ctl));
		chk("ana batch", exp_ana(12), 32'(ana));
		cin = 1'b0;
		tk(24'sd3, 4);
		chk("batch clr", 0, batch);
		chk("batch out", 0, 32'(ctl));
		cfg(PM_RATE, CM_OFF, IM_OFF, AS_BATCH, 1'b0);
		chk("ana fallback", exp_ana(flow), 32'(ana));
		chk("off hold", 0, 32'(hold));
		cin = 1'b1;
		cyc(6);
		chk("off zero", 0, 32'(busy));
		// earlier ticks left a balance and edge count behind; start totals fresh
		nrst = 1'b0;
		cyc(2);
		nrst = 1'b1;
		cyc(2);
		chk("reset batch", 0, batch);
		cfg(PM_TOTAL, CM_OFF, IM_HOLD, AS_FLOW, 1'b0);
		cin = 1'b0;
		clear();
		cyc(2);
		chk("hold", 1, 32'(hold));
		tk(24'sd4, 12);
		chk("hold edges", 0, 32'(edges));
		cfg(PM_TOTAL, CM_OFF, IM_OFF, AS_FLOW, 1'b0);
		clear();
		for (int k = 0; k < 4; k++)
			tk(24'sd2, 12);
		chk("tot edges", 4, 32'(edges));
		tk(-24'sd2, 12);
		tk(-24'sd2, 12);
		tk(24'sd2, 12);
		tk(24'sd2, 12);
		chk("tot payback", 4, 32'(edges));
		tk(24'sd2, 12);
		chk("tot resume", 5, 32'(edges));
		flow = 10;
		tk(24'sd2, 12);
		chk("tot cutoff", 5, 32'(edges));
		flow = 1000;
		// burst of ticks: owed edges must be spread out, not bunched
		for (int k = 0; k < 8; k++)
			tk(24'sd2, 1);
		cyc(120);
		chk("tot burst", 13, 32'(edges));
		rng("tot gap", GAP, 999999, gap);
		cfg(PM_TOTAL, CM_PHASE, IM_OFF, AS_FLOW, 1'b0);
		clear();
		for (int k = 0; k < 8; k++)
			tk(24'sd1, 1);
		cyc(80);
		chk("phase edges", 4, 32'(edges));
		chk("phase both", 0, 32'(both));
		flow = 24'sh7FFFFF;
		gain = 16'hFFFF;
		cfg(PM_RATE, CM_OFF, IM_OFF, AS_FLOW, 1'b0);
		clear();
		cyc(10000);
		rng("rate max", 9, 11, edges);
		flow = 5000;
		gain = 16'h0100;
		clear();
		cyc(10000);
		rng("rate", 4, 6, edges);
		flow = 10;
		lo = -1000;
		hi = 1000;
		cyc(10);
		clear();
		cyc(2000);
		chk("rate cutoff", 0, 32'(edges));
		chk("ana cutoff", exp_ana(0), 32'(ana));
		for (int z = 0; z < 2; z++) begin
			zslow = 1'(z);
			cin = 1'b0;
			cfg(PM_RATE, CM_OFF, IM_ZERO, AS_FLOW, 1'b0);
			cin = 1'b1;
			wait_busy(1'b1);
			rng("zero start", 3, 4, n);
			wait_busy(1'b0);
			chk("zero len", 32'(z ? ZS : ZF), 32'(n));
			cyc(5);
			chk("zero again", 0, 32'(busy));
		end
		thz = 14'd10000;
		tlev = 1'b1;
		tana = 16'h1234;
		cin = 1'b0;
		cfg(PM_RATE, CM_OFF, IM_ZERO, AS_FLOW, 1'b1);
		cin = 1'b1;
		clear();
		cyc(10000);
		rng("test hz", 9, 11, edges);
		chk("test ctl", 1, 32'(ctl));
		chk("test ana", 32'h1234, 32'(ana));
		chk("test in", 1, 32'(lvl));
		chk("test zero", 0, 32'(busy));
		tlev = 1'b0;
		cin = 1'b0;
		cyc(4);
		chk("test ctl", 0, 32'(ctl));
		chk("test in", 0, 32'(lvl));
		test_done();
	end
endmodule : tb_top
